//--- src/gpb_pin_bank.sv
`timescale 1ns/10ps
module gpb_pin_bank
    import gpb_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic I_MAIN_POR,
    input wire logic I_HARD_RESET,
    input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [DATA_W-1:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [DATA_W-1:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic [NUM_PINS-1:0] I_PIN_IN,
    output logic [NUM_PINS-1:0] O_PIN_OUT,
    output logic [NUM_PINS-1:0] O_PIN_OE,
    input wire logic I_KEYBOARD_RESET_OUT,
    input wire logic I_GATE_A20_OUT,
    input wire logic I_DRIVE_DENSITY_SEL0,
    input wire logic I_DRIVE_DENSITY_SEL1,
    input wire logic I_POWER_EVENT,
    input wire logic I_FLOPPY_PARPORT_SELECT,
    output logic [REG_W-1:0] O_DEVICE_DISABLE,
    output logic O_LOCK_MODE,
    output logic O_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [REG_W-1:0] ctl_q [NUM_PINS];
    logic [NUM_PINS-1:0] data_q;
    logic [REG_W-1:0] dev_dis_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] mask_q;
    logic [NUM_PINS-1:0] pin_in_q;
    logic [NUM_PINS-1:0] pin_prev_q;
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [REG_W-1:0] wdata_q;
    logic wstrb0_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic irq_q;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode of pin modes
    logic [1:0] sel_4_1;
    logic [1:0] sel_4_3;
    logic lock_mode;
    logic [NUM_PINS-1:0] alt_out;
    logic [NUM_PINS-1:0] alt_val;
    logic [NUM_PINS-1:0] force_in;
    logic [NUM_PINS-1:0] force_no_inv;
    logic [NUM_PINS-1:0] pin_val;
    logic [NUM_PINS-1:0] pin_edge;

    assign sel_4_1 = ctl_q[PIN_4_1][3:2];
    assign sel_4_3 = ctl_q[PIN_4_3][3:2];
    assign lock_mode = (sel_4_3 == SEL_01);
    assign pin_edge = pin_in_q ^ pin_prev_q;

    always_comb begin
        alt_out = '0;
        alt_val = '0;
        force_in = '0;
        force_no_inv = '0;
        alt_out[PIN_3_6] = ctl_q[PIN_3_6][BIT_ALT];
        alt_val[PIN_3_6] = I_KEYBOARD_RESET_OUT;
        alt_out[PIN_3_7] = ctl_q[PIN_3_7][BIT_ALT];
        alt_val[PIN_3_7] = I_GATE_A20_OUT;
        alt_out[PIN_4_0] = ctl_q[PIN_4_0][BIT_ALT];
        alt_val[PIN_4_0] = I_DRIVE_DENSITY_SEL0;
        // power event drives low when asserted
        alt_out[PIN_4_2] = ctl_q[PIN_4_2][BIT_ALT];
        alt_val[PIN_4_2] = ~I_POWER_EVENT;
        case (sel_4_1)
            SEL_10: begin
                force_in[PIN_4_1] = 1'b1;
            end
            SEL_01: begin
                alt_out[PIN_4_1] = 1'b1;
                alt_val[PIN_4_1] = I_DRIVE_DENSITY_SEL1;
            end
            default: begin
                alt_out[PIN_4_1] = 1'b0;
            end
        endcase
        case (sel_4_3)
            SEL_11: begin
                force_in[PIN_4_3] = 1'b1;
            end
            SEL_10: begin
                alt_out[PIN_4_3] = 1'b1;
                alt_val[PIN_4_3] = I_FLOPPY_PARPORT_SELECT;
            end
            SEL_01: begin
                force_in[PIN_4_3] = 1'b1;
                force_no_inv[PIN_4_3] = 1'b1;
            end
            default: begin
                alt_out[PIN_4_3] = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin drive and sampling
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            logic pol;
            logic drive;
            logic value;
            assign pol = ctl_q[gi][BIT_POL] & ~force_no_inv[gi];
            assign pin_val[gi] = pin_in_q[gi] ^ pol;
            assign drive = alt_out[gi] | (~ctl_q[gi][BIT_DIR] & ~force_in[gi]);
            assign value = (alt_out[gi] ? alt_val[gi] : data_q[gi]) ^ pol;

            always_ff @(posedge I_REF_CLK) begin
                if (I_RESET) begin
                    pin_out_q[gi] <= 1'b0;
                    pin_oe_q[gi] <= 1'b0;
                end else if (I_CE) begin
                    if (ctl_q[gi][BIT_ODRAIN]) begin
                        pin_out_q[gi] <= 1'b0;
                        pin_oe_q[gi] <= drive & ~value;
                    end else begin
                        pin_out_q[gi] <= value;
                        pin_oe_q[gi] <= drive;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            pin_in_q <= '0;
            pin_prev_q <= '0;
        end else if (I_CE) begin
            pin_in_q <= I_PIN_IN;
            pin_prev_q <= pin_in_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel
    logic wr_en;
    logic [5:0] wr_idx;
    logic wr_hit;

    assign wr_en = aw_have_q & w_have_q & ~bvalid_q & wstrb0_q;
    assign wr_idx = awaddr_q[ADDR_W-1:2];

    always_comb begin
        case (wr_idx)
            IDX_PIN_3_6, IDX_PIN_3_7, IDX_PIN_4_0, IDX_PIN_4_1, IDX_PIN_4_2, IDX_PIN_4_3,
            IDX_DATA, IDX_DEV_DISABLE, IDX_IRQ_STATUS, IDX_IRQ_MASK: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (I_CE) begin
            if (awready_q && I_AXI_AWVALID) begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= I_AXI_AWADDR;
            end else if (!aw_have_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (wready_q && I_AXI_WVALID) begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= I_AXI_WDATA[REG_W-1:0];
                wstrb0_q <= I_AXI_WSTRB[0];
            end else if (!w_have_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (aw_have_q && w_have_q && !bvalid_q) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end else if (bvalid_q && I_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin control registers
    genvar gr;
    generate
        for (gr = 0; gr < NUM_PINS; gr++) begin : g_ctl
            localparam logic [5:0] IDX = IDX_PIN_3_6 + 6'(gr);
            localparam logic [7:0] WMASK = (gr == PIN_4_1 || gr == PIN_4_3) ? MASK_SEL2 : MASK_SEL1;
            always_ff @(posedge I_REF_CLK) begin
                if (I_RESET) begin
                    ctl_q[gr] <= CTL_RESET;
                end else if (gr == PIN_4_3 && (I_MAIN_POR || I_HARD_RESET)) begin
                    ctl_q[gr][3:2] <= SEL_GPIO;
                end else if (I_CE && wr_en && wr_idx == IDX) begin
                    ctl_q[gr] <= wdata_q & WMASK;
                    if (gr == PIN_4_3 && lock_mode) begin
                        ctl_q[gr][3:2] <= SEL_01;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // data, device disable, interrupt registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            data_q <= '0;
        end else if (I_CE && wr_en && wr_idx == IDX_DATA) begin
            data_q <= wdata_q[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            dev_dis_q <= '0;
        end else if (I_CE && wr_en && wr_idx == IDX_DEV_DISABLE) begin
            // pin high blocks writes in lock mode
            if (!(lock_mode && pin_in_q[PIN_4_3])) begin
                dev_dis_q <= wdata_q;
            end
        end
    end

    logic [ST_W-1:0] st_set;
    always_comb begin
        st_set = '0;
        st_set[ST_EDGE_IRQ2] = (sel_4_1 == SEL_10) & pin_edge[PIN_4_1];
        st_set[ST_EDGE_IRQ3] = (sel_4_3 == SEL_11) & pin_edge[PIN_4_3];
        // port select event on either edge
        st_set[ST_PORT_SEL_EVT] = (sel_4_3 == SEL_10) & pin_edge[PIN_4_3];
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            status_q <= '0;
        end else if (I_CE) begin
            if (wr_en && wr_idx == IDX_IRQ_STATUS) begin
                status_q <= (status_q & ~wdata_q[ST_W-1:0]) | st_set;
            end else begin
                status_q <= status_q | st_set;
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            mask_q <= '0;
        end else if (I_CE && wr_en && wr_idx == IDX_IRQ_MASK) begin
            mask_q <= wdata_q[ST_W-1:0];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            irq_q <= 1'b0;
        end else if (I_CE) begin
            irq_q <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel
    logic [REG_W-1:0] rd_val;
    logic rd_hit;
    logic [5:0] rd_idx;
    assign rd_idx = I_AXI_ARADDR[ADDR_W-1:2];

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (rd_idx)
            IDX_PIN_3_6: rd_val = ctl_q[PIN_3_6];
            IDX_PIN_3_7: rd_val = ctl_q[PIN_3_7];
            IDX_PIN_4_0: rd_val = ctl_q[PIN_4_0];
            IDX_PIN_4_1: rd_val = ctl_q[PIN_4_1];
            IDX_PIN_4_2: rd_val = ctl_q[PIN_4_2];
            IDX_PIN_4_3: rd_val = ctl_q[PIN_4_3];
            IDX_DATA: rd_val = {2'h0, pin_val};
            IDX_DEV_DISABLE: rd_val = dev_dis_q;
            IDX_IRQ_STATUS: rd_val = {5'h0, status_q};
            IDX_IRQ_MASK: rd_val = {5'h0, mask_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (I_CE) begin
            if (arready_q && I_AXI_ARVALID) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= {24'h0, rd_val};
                rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
            end else if (rvalid_q && I_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    logic lock_q;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            lock_q <= 1'b0;
        end else if (I_CE) begin
            lock_q <= lock_mode;
        end
    end

    assign O_AXI_AWREADY = awready_q;
    assign O_AXI_WREADY = wready_q;
    assign O_AXI_BVALID = bvalid_q;
    assign O_AXI_BRESP = bresp_q;
    assign O_AXI_ARREADY = arready_q;
    assign O_AXI_RVALID = rvalid_q;
    assign O_AXI_RDATA = rdata_q;
    assign O_AXI_RRESP = rresp_q;
    assign O_PIN_OUT = pin_out_q;
    assign O_PIN_OE = pin_oe_q;
    assign O_DEVICE_DISABLE = dev_dis_q;
    assign O_LOCK_MODE = lock_q;
    assign O_IRQ = irq_q;

endmodule : gpb_pin_bank

//--- src/gpb_pkg.sv
//
// Contract
// - bit 0: one means input, zero output
// - bit 1 inverts pin value when set
// - bit 7: one open-drain, zero push-pull
// - bit 2 routes single alternate function
// - pin 4.1 selector: edge irq, density, gpio
// - pin 4.3 code 11: edge interrupt input
// - pin 4.3 code 10: port select, edge events
// - lock mode: non-inverted input, bits ignored
// - lock code sticks until a reset
// - pin 4.3 selector cleared by every reset
// - lock, pin high: disable register read-only
// - lock, pin low: disable register writable
// - power event output active low, bit 1 still inverts
package gpb_pkg;
    localparam int NUM_PINS = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // register indexes, byte address is four times the index
    localparam logic [5:0] IDX_PIN_3_6 = 6'h39;
    localparam logic [5:0] IDX_PIN_3_7 = 6'h3a;
    localparam logic [5:0] IDX_PIN_4_0 = 6'h3b;
    localparam logic [5:0] IDX_PIN_4_1 = 6'h3c;
    localparam logic [5:0] IDX_PIN_4_2 = 6'h3d;
    localparam logic [5:0] IDX_PIN_4_3 = 6'h3e;
    localparam logic [5:0] IDX_DATA = 6'h30;
    localparam logic [5:0] IDX_DEV_DISABLE = 6'h31;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h32;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h33;
    // pin positions in the bank
    localparam int PIN_3_6 = 0;
    localparam int PIN_3_7 = 1;
    localparam int PIN_4_0 = 2;
    localparam int PIN_4_1 = 3;
    localparam int PIN_4_2 = 4;
    localparam int PIN_4_3 = 5;
    // control fields
    localparam int BIT_DIR = 0;
    localparam int BIT_POL = 1;
    localparam int BIT_ALT = 2;
    localparam int BIT_ODRAIN = 7;
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_01 = 2'h1;
    localparam logic [1:0] SEL_10 = 2'h2;
    localparam logic [1:0] SEL_11 = 2'h3;
    localparam logic [7:0] CTL_RESET = 8'h01;
    localparam logic [7:0] MASK_SEL1 = 8'h87;
    localparam logic [7:0] MASK_SEL2 = 8'h8f;
    // status bits
    localparam int ST_EDGE_IRQ2 = 0;
    localparam int ST_EDGE_IRQ3 = 1;
    localparam int ST_PORT_SEL_EVT = 2;
    localparam int ST_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : gpb_pkg

//--- verif/gpb_board_model.sv
`timescale 1ns/10ps
module gpb_board_model
    import gpb_pkg::*;
(
    input wire logic [NUM_PINS-1:0] i_pin_out,
    input wire logic [NUM_PINS-1:0] i_pin_oe,
    input wire logic [NUM_PINS-1:0] i_pull,
    output logic [NUM_PINS-1:0] o_pin_level
);
    // driven pin shows the device level, released pin the board pull
    always_comb begin
        for (int k = 0; k < NUM_PINS; k++) begin
            o_pin_level[k] = i_pin_oe[k] ? i_pin_out[k] : i_pull[k];
        end
    end
endmodule : gpb_board_model

//--- verif/gpb_pin_bank_properties.sv
`timescale 1ns/10ps
module gpb_pin_bank_properties
    import gpb_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic I_MAIN_POR,
    input wire logic I_HARD_RESET,
    input wire logic I_AXI_AWVALID,
    input wire logic O_AXI_AWREADY,
    input wire logic I_AXI_WVALID,
    input wire logic O_AXI_WREADY,
    input wire logic [1:0] O_AXI_BRESP,
    input wire logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic I_AXI_ARVALID,
    input wire logic O_AXI_ARREADY,
    input wire logic [DATA_W-1:0] O_AXI_RDATA,
    input wire logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic [NUM_PINS-1:0] I_PIN_IN,
    input wire logic [NUM_PINS-1:0] O_PIN_OE,
    input wire logic [REG_W-1:0] O_DEVICE_DISABLE,
    input wire logic O_LOCK_MODE
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RESET);
    ////////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
    endsequence
    sequence s_rd_taken;
        I_AXI_ARVALID && O_AXI_ARREADY;
    endsequence
    sequence s_no_clear;
        !I_MAIN_POR && !I_HARD_RESET && !$past(I_MAIN_POR) && !$past(I_HARD_RESET);
    endsequence
    ////////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] O_AXI_BVALID)
        else $error("write response missing");
    a_bresp_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
        else $error("write response dropped");
    a_read_answer: assert property (s_rd_taken |=> O_AXI_RVALID)
        else $error("read data missing");
    a_rdata_hold: assert property (O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
        else $error("read data dropped");
    a_rdata_upper: assert property (O_AXI_RVALID |-> O_AXI_RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    a_lock_input: assert property (O_LOCK_MODE && $past(O_LOCK_MODE) |-> !O_PIN_OE[PIN_4_3])
        else $error("locked pin driven");
    a_lock_sticks: assert property ((O_LOCK_MODE and s_no_clear) |=> O_LOCK_MODE)
        else $error("lock lost without reset");
    a_disable_frozen: assert property (((O_LOCK_MODE && I_PIN_IN[PIN_4_3]
        && $past(I_PIN_IN[PIN_4_3]) && $past(I_PIN_IN[PIN_4_3], 2)) and s_no_clear)
        |=> $stable(O_DEVICE_DISABLE))
        else $error("disable register changed");
endmodule : gpb_pin_bank_properties

bind gpb_pin_bank gpb_pin_bank_properties i_props (.I_REF_CLK, .I_RESET, .I_MAIN_POR, .I_HARD_RESET,
    .I_AXI_AWVALID, .O_AXI_AWREADY, .I_AXI_WVALID, .O_AXI_WREADY, .O_AXI_BRESP, .O_AXI_BVALID,
    .I_AXI_BREADY, .I_AXI_ARVALID, .O_AXI_ARREADY, .O_AXI_RDATA, .O_AXI_RVALID, .I_AXI_RREADY,
    .I_PIN_IN, .O_PIN_OE, .O_DEVICE_DISABLE, .O_LOCK_MODE);

//--- verif/tb.sv
`timescale 1ns/10ps
module tb
    import gpb_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic mpor = 1'h0, hrst = 1'h0, fps = 1'h0;
    logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [5:0] pull = 6'h0;
    logic [4:0] alt = 5'h0;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, lock, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] lvl, pout, poe;
    logic [7:0] devdis;
    int err_total = 0;
    int check_count = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    gpb_pin_bank i_dut (
        .I_REF_CLK(clk), .I_RESET(rst), .I_CE(1'h1), .I_MAIN_POR(mpor), .I_HARD_RESET(hrst),
        .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(aw_rdy), .I_AXI_WDATA(wd),
        .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wv), .O_AXI_WREADY(w_rdy), .O_AXI_BRESP(bresp),
        .O_AXI_BVALID(b_vld), .I_AXI_BREADY(bry), .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv),
        .O_AXI_ARREADY(ar_rdy), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(r_vld),
        .I_AXI_RREADY(rry), .I_PIN_IN(lvl), .O_PIN_OUT(pout), .O_PIN_OE(poe),
        .I_KEYBOARD_RESET_OUT(alt[0]), .I_GATE_A20_OUT(alt[1]), .I_DRIVE_DENSITY_SEL0(alt[2]),
        .I_DRIVE_DENSITY_SEL1(alt[3]), .I_POWER_EVENT(alt[4]), .I_FLOPPY_PARPORT_SELECT(fps),
        .O_DEVICE_DISABLE(devdis), .O_LOCK_MODE(lock), .O_IRQ(irq)
    );
    gpb_board_model i_board (.i_pin_out(pout), .i_pin_oe(poe), .i_pull(pull), .o_pin_level(lvl));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awa <= {idx, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        for (n = 0; n < 50 && !b_vld; n++) begin
            @(posedge clk);
            if (aw_rdy) awv <= 1'h0;
            if (w_rdy) wv <= 1'h0;
        end
        bry <= 1'h0;
        chk("bresp", {5'h0, b_vld, bresp}, {5'h0, 1'h1, er});
    endtask : wr

    task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [7:0] m,
                          input logic [7:0] e, input logic [1:0] er);
        int n;
        @(posedge clk);
        ara <= {idx, 2'h0};
        arv <= 1'h1;
        rry <= 1'h1;
        for (n = 0; n < 50 && !r_vld; n++) begin
            @(posedge clk);
            if (ar_rdy) arv <= 1'h0;
        end
        rry <= 1'h0;
        chk(nm, rdata[7:0] & m, e);
        chk("rresp", {5'h0, r_vld, rresp}, {5'h0, 1'h1, er});
    endtask : rd_chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int k = 0; k < 6; k++) begin
            rd_chk("ctl_reset", IDX_PIN_3_6 + 6'(k), 8'hff, 8'h01, RESP_OKAY);
        end
        rd_chk("unmapped", 6'h00, 8'hff, 8'h00, RESP_DECERR);
        wr(6'h00, 8'hff, RESP_DECERR);
        chk("oe_reset", {2'h0, poe}, 8'h00);
        wr(IDX_PIN_4_0, 8'hff, RESP_OKAY);
        rd_chk("reserved1", IDX_PIN_4_0, 8'hff, 8'h87, RESP_OKAY);
        wr(IDX_PIN_4_1, 8'hff, RESP_OKAY);
        rd_chk("reserved2", IDX_PIN_4_1, 8'hff, 8'h8f, RESP_OKAY);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_gpio;
        wr(IDX_PIN_4_0, 8'h00, RESP_OKAY);
        wr(IDX_DATA, 8'h04, RESP_OKAY);
        tick(2);
        chk("push_pull", {6'h0, poe[2], pout[2]}, 8'h03);
        wr(IDX_PIN_4_0, 8'h02, RESP_OKAY);
        tick(2);
        chk("inverted", {6'h0, poe[2], pout[2]}, 8'h02);
        wr(IDX_PIN_4_0, 8'h80, RESP_OKAY);
        tick(2);
        chk("od_release", {7'h0, poe[2]}, 8'h00);
        wr(IDX_DATA, 8'h00, RESP_OKAY);
        tick(2);
        chk("od_low", {6'h0, poe[2], pout[2]}, 8'h02);
        wr(IDX_PIN_4_0, 8'h01, RESP_OKAY);
        pull <= 6'h04;
        tick(3);
        chk("input_oe", {7'h0, poe[2]}, 8'h00);
        rd_chk("in_level", IDX_DATA, 8'h04, 8'h04, RESP_OKAY);
        wr(IDX_PIN_4_0, 8'h03, RESP_OKAY);
        rd_chk("in_invert", IDX_DATA, 8'h04, 8'h00, RESP_OKAY);
        $display("t_gpio done");
    endtask : t_gpio

    task automatic t_alt;
        logic [4:0] pat [3] = '{5'h15, 5'h0a, 5'h00};
        for (int k = 0; k < 5; k++) begin
            wr(IDX_PIN_3_6 + 6'(k), 8'h04, RESP_OKAY);
        end
        for (int k = 0; k < 3; k++) begin
            alt <= pat[k];
            tick(3);
            chk("alt_out", {3'h0, pout[4:0]}, {3'h0, pat[k] ^ 5'h10});
            chk("alt_oe", {3'h0, poe[4:0]}, 8'h1f);
        end
        $display("t_alt done");
    endtask : t_alt

    task automatic t_irq;
        wr(IDX_PIN_4_1, 8'h09, RESP_OKAY);
        wr(IDX_PIN_4_3, 8'h0d, RESP_OKAY);
        wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
        pull <= 6'h28;
        tick(6);
        rd_chk("rise_status", IDX_IRQ_STATUS, 8'h07, 8'h03, RESP_OKAY);
        chk("irq_on", {7'h0, irq}, 8'h01);
        wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
        tick(2);
        chk("irq_masked", {7'h0, irq}, 8'h00);
        pull <= 6'h00;
        tick(6);
        rd_chk("fall_status", IDX_IRQ_STATUS, 8'h07, 8'h03, RESP_OKAY);
        wr(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
        wr(IDX_PIN_4_3, 8'h08, RESP_OKAY);
        fps <= 1'h1;
        tick(6);
        chk("sel_out", {6'h0, poe[5], pout[5]}, 8'h03);
        rd_chk("sel_event", IDX_IRQ_STATUS, 8'h07, 8'h04, RESP_OKAY);
        wr(IDX_PIN_4_3, 8'h0a, RESP_OKAY);
        tick(2);
        chk("sel_invert", {7'h0, pout[5]}, 8'h00);
        pull <= 6'h20;
        $display("t_irq done");
    endtask : t_irq

    task automatic t_lock;
        wr(IDX_PIN_4_3, 8'h07, RESP_OKAY);
        tick(3);
        chk("lock_on", {6'h0, lock, poe[5]}, 8'h02);
        rd_chk("lock_level", IDX_DATA, 8'h20, 8'h20, RESP_OKAY);
        wr(IDX_PIN_4_3, 8'h01, RESP_OKAY);
        rd_chk("lock_sel", IDX_PIN_4_3, 8'h0c, 8'h04, RESP_OKAY);
        wr(IDX_DEV_DISABLE, 8'h5a, RESP_OKAY);
        rd_chk("dd_ro", IDX_DEV_DISABLE, 8'hff, 8'h00, RESP_OKAY);
        pull <= 6'h00;
        tick(3);
        wr(IDX_DEV_DISABLE, 8'h5a, RESP_OKAY);
        rd_chk("dd_rw", IDX_DEV_DISABLE, 8'hff, 8'h5a, RESP_OKAY);
        chk("dd_port", devdis, 8'h5a);
        for (int r = 0; r < 3; r++) begin
            wr(IDX_PIN_4_3, 8'h05, RESP_OKAY);
            tick(2);
            chk("relock", {7'h0, lock}, 8'h01);
            {rst, hrst, mpor} <= 3'h1 << r;
            tick(1);
            {rst, hrst, mpor} <= 3'h0;
            tick(3);
            rd_chk("sel_clear", IDX_PIN_4_3, 8'h0c, 8'h00, RESP_OKAY);
            chk("lock_off", {7'h0, lock}, 8'h00);
        end
        $display("t_lock done");
    endtask : t_lock

    ////////////////////////////////////////////////////////////////
    initial begin
        tick(16);
        rst <= 1'h0;
        t_reset;
        t_gpio;
        t_alt;
        t_irq;
        t_lock;
        finish_test;
    end

    initial begin
        tick(20000);
        err_total++;
        finish_test;
    end
endmodule : tb
